// *** hdl/scbf_params.svh ***
// constants for the serial clock, buffer and flag block
`ifndef SCBF_PARAMS_SVH
`define SCBF_PARAMS_SVH
`define SCBF_MODE_IO 2'h0
`define SCBF_CSEL_TIMER 2'h0
`define SCBF_CSEL_BAUD 2'h1
`define SCBF_CSEL_SYS 2'h2
`define SCBF_CSEL_EXT 2'h3
`define SCBF_DPX_RX 2'h1
`define SCBF_DPX_TX 2'h2
`define SCBF_DPX_FULL 2'h3
`define SCBF_FIFO_DEPTH 8
`define SCBF_LIM_NONE 4'h0
`define SCBF_LIM_HALF 4'h2
`define SCBF_LIM_WHOLE 4'h4
`define SCBF_DIV_LAST 4'hf
`define SCBF_SAMPLE_AT 4'h7
`define SCBF_DIV_RST 4'h0
`define SCBF_BYTE_RST 8'h00
`endif

// *** hdl/scbf_pkg.sv ***
// types shared by the serial clock, buffer and flag block
package scbf_pkg;
  typedef logic [1:0] scbf_code_type;
  typedef logic [7:0] scbf_byte_type;
  typedef logic [3:0] scbf_level_type;
endpackage : scbf_pkg

// *** hdl/scbf_fifo.sv ***
// small fifo with a run-time usable depth limit
module scbf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic [$clog2(DEPTH):0] limit_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // full is judged against the usable depth, not the storage depth
  assign in_ready_out = (count < limit_in);
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign level_out = count;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // pointer and count update
  always_comb
  begin
    next_wr_ptr = wr_ptr + AW'(push);
    next_rd_ptr = rd_ptr + AW'(pop);
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_in)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
  end

  // registers; storage is not reset
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push & ~flush_in)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule : scbf_fifo

// *** hdl/scbf_core.sv ***
// transfer clock selection, buffers, fifo split and status/error flags
`include "scbf_params.svh"

module scbf_core (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire scbf_pkg::scbf_code_type mode_select_in,
  input wire logic io_clock_input_in,
  input wire logic edge_select_in,
  input wire scbf_pkg::scbf_code_type uart_clock_select_in,
  input wire logic double_buffer_in,
  input wire logic fifo_enable_in,
  input wire scbf_pkg::scbf_code_type duplex_select_in,
  input wire logic parity_enable_in,
  input wire logic parity_even_in,
  input wire logic baud_clock_in,
  input wire logic timer_match_in,
  input wire logic serial_clock_pin_in,
  input wire logic rx_pin_in,
  input wire logic rx_frame_done_in,
  input wire scbf_pkg::scbf_byte_type rx_frame_data_in,
  input wire logic rx_parity_bit_in,
  input wire logic rx_stop_bit_in,
  input wire logic rx_read_in,
  input wire logic status_read_in,
  input wire logic control_read_in,
  input wire logic rx_fifo_clear_in,
  input wire logic tx_fifo_clear_in,
  input wire logic tx_write_in,
  input wire scbf_pkg::scbf_byte_type tx_write_data_in,
  input wire logic tx_load_in,
  input wire logic tx_shift_idle_in,
  input wire logic transmit_buffer_clear_in,
  output logic tx_write_ready_out,
  output scbf_pkg::scbf_byte_type tx_shift_data_out,
  output scbf_pkg::scbf_byte_type rx_data_out,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  output logic serial_shift_clock_out,
  output logic bit_tick_out,
  output logic prescaler_run_out,
  output logic rx_bit_out,
  output logic rx_bit_valid_out,
  output logic transmit_buffer_empty_flag_out,
  output logic receive_buffer_full_flag_out,
  output logic overrun_flag_out,
  output logic parity_underrun_flag_out,
  output logic framing_flag_out,
  output logic transmit_running_flag_out,
  output logic clock_stopped_out,
  output scbf_pkg::scbf_level_type rx_fifo_level_out,
  output scbf_pkg::scbf_level_type tx_fifo_level_out
);
  import scbf_pkg::*;

  logic clk_meta, clk_sync, clk_prev, rxd_meta, rxd_sync;
  logic baud_half, timer_ff, stop_prev;
  logic [2:0] rx_hist, next_rx_hist;
  logic rx_filt, next_rx_filt;
  logic [3:0] div_cnt, next_div_cnt;
  logic next_baud_half, next_timer_ff, next_shift_clock, next_bit_tick;
  logic next_rx_bit, next_rx_bit_valid;
  scbf_byte_type rx_buf, next_rx_buf, tx_buf, next_tx_buf;
  scbf_byte_type next_rx_data, next_tx_shift_data;
  logic rx_full, next_rx_full, tx_full, next_tx_full, tx_empty, next_tx_empty;
  logic ovr, next_ovr, per, next_per, fer, next_fer;
  logic io_mode, io_clk_out, rx_double, fifo_on, shift_tick, io_tick;
  logic clock_stop, rx_blocked, tx_starved, rx_move, tx_room;
  logic rx_pop, tx_pop, tx_push, tx_buf_write;
  scbf_level_type rx_lim, tx_lim;
  logic rxf_ready, rxf_valid, txf_ready, txf_valid;
  scbf_byte_type rxf_data, txf_data;

  // mode decode, buffering and fifo split
  assign io_mode = (mode_select_in == `SCBF_MODE_IO);
  assign io_clk_out = io_mode & ~io_clock_input_in;
  assign rx_double = double_buffer_in | ~io_clk_out;
  assign fifo_on = double_buffer_in & fifo_enable_in;
  always_comb
  begin
    rx_lim = `SCBF_LIM_NONE;
    tx_lim = `SCBF_LIM_NONE;
    if (fifo_on)
    begin
      unique case (duplex_select_in)
        `SCBF_DPX_RX: rx_lim = `SCBF_LIM_WHOLE;
        `SCBF_DPX_TX: tx_lim = `SCBF_LIM_WHOLE;
        `SCBF_DPX_FULL:
        begin
          rx_lim = `SCBF_LIM_HALF;
          tx_lim = `SCBF_LIM_HALF;
        end
        default: rx_lim = `SCBF_LIM_NONE;
      endcase
    end
  end

  // receive and transmit fifos
  scbf_fifo #(.WIDTH(8), .DEPTH(`SCBF_FIFO_DEPTH)) rx_fifo (
    .clock_in(clock_in), .rst_in(rst_in), .flush_in(rx_fifo_clear_in),
    .limit_in(rx_lim), .in_valid_in(rx_move), .in_data_in(rx_buf),
    .in_ready_out(rxf_ready), .out_valid_out(rxf_valid),
    .out_data_out(rxf_data), .out_ready_in(rx_pop), .level_out(rx_fifo_level_out)
  );
  scbf_fifo #(.WIDTH(8), .DEPTH(`SCBF_FIFO_DEPTH)) tx_fifo (
    .clock_in(clock_in), .rst_in(rst_in), .flush_in(tx_fifo_clear_in),
    .limit_in(tx_lim), .in_valid_in(tx_push), .in_data_in(tx_write_data_in),
    .in_ready_out(txf_ready), .out_valid_out(txf_valid),
    .out_data_out(txf_data), .out_ready_in(tx_pop), .level_out(tx_fifo_level_out)
  );

  // handshakes with fifos and cpu
  assign rx_move = fifo_on & rx_full;
  assign rx_blocked = rx_full & ~(rx_move & rxf_ready);
  assign tx_starved = tx_shift_idle_in & ~tx_full & ~txf_valid;
  assign clock_stop = io_clk_out & (rx_blocked | tx_starved);
  assign rx_pop = rx_read_in & fifo_on & rxf_valid;
  assign tx_room = double_buffer_in | tx_shift_idle_in;
  assign tx_buf_write = tx_write_in & ~tx_full & ~txf_valid & tx_room;
  assign tx_push = tx_write_in & fifo_on & ~tx_buf_write;
  assign tx_write_ready_out = (~tx_full & ~txf_valid & tx_room) | (fifo_on & txf_ready);
  assign tx_pop = txf_valid & (transmit_buffer_clear_in | (tx_load_in & tx_full));

  // transfer clock selection and the divide by sixteen
  assign io_tick = baud_clock_in & ~baud_half & ~clock_stop;
  always_comb
  begin
    next_baud_half = baud_half ^ (baud_clock_in & ~clock_stop);
    next_timer_ff = timer_ff ^ timer_match_in;
    shift_tick = 1'b0;
    if (io_clk_out)
      shift_tick = io_tick;
    else if (io_mode)
      shift_tick = edge_select_in ? (~clk_sync & clk_prev) : (clk_sync & ~clk_prev);
    else
    begin
      unique case (uart_clock_select_in)
        `SCBF_CSEL_TIMER: shift_tick = timer_match_in & ~timer_ff;
        `SCBF_CSEL_BAUD: shift_tick = baud_clock_in;
        `SCBF_CSEL_SYS: shift_tick = 1'b1;
        `SCBF_CSEL_EXT: shift_tick = clk_sync & ~clk_prev;
      endcase
    end
    next_shift_clock = shift_tick;
    next_div_cnt = div_cnt;
    next_bit_tick = 1'b0;
    next_rx_hist = rx_hist;
    next_rx_filt = rx_filt;
    next_rx_bit = rx_bit_out;
    next_rx_bit_valid = 1'b0;
    if (io_mode)
      next_div_cnt = `SCBF_DIV_RST;
    else if (shift_tick)
    begin
      next_div_cnt = div_cnt + 4'h1;
      next_bit_tick = (div_cnt == `SCBF_DIV_LAST);
      next_rx_hist = {rx_hist[1:0], rxd_sync};
      if (&rx_hist | ~|rx_hist)
        next_rx_filt = rx_hist[0];
      if (div_cnt == `SCBF_SAMPLE_AT)
      begin
        next_rx_bit = rx_filt;
        next_rx_bit_valid = 1'b1;
      end
    end
  end

  // buffers and flags
  always_comb
  begin
    next_rx_buf = rx_buf;
    next_rx_full = rx_full;
    next_rx_data = rx_data_out;
    next_tx_buf = tx_buf;
    next_tx_full = tx_full;
    next_tx_empty = tx_empty;
    next_tx_shift_data = tx_shift_data_out;
    next_ovr = ovr;
    next_per = per;
    next_fer = fer;
    if (rx_move & rxf_ready)
      next_rx_full = 1'b0;
    if (rx_read_in)
    begin
      next_rx_data = rx_pop ? rxf_data : rx_buf;
      if (~rx_pop)
        next_rx_full = 1'b0;
    end
    if (status_read_in)
      next_rx_full = 1'b0;
    if (control_read_in)
    begin
      next_ovr = 1'b0;
      next_per = 1'b0;
      next_fer = 1'b0;
    end
    if (rx_frame_done_in)
    begin
      if (rx_blocked & rx_double)
        next_ovr = 1'b1;
      else
      begin
        next_rx_buf = rx_frame_data_in;
        next_rx_full = 1'b1;
      end
      if (~io_mode & parity_enable_in & (^rx_frame_data_in ^ rx_parity_bit_in ^ ~parity_even_in))
        next_per = 1'b1;
      if (~io_mode & ~rx_stop_bit_in)
        next_fer = 1'b1;
    end
    if (io_mode & double_buffer_in)
    begin
      if (~io_clk_out & shift_tick & tx_starved)
        next_per = 1'b1;
      if (clock_stop & ~stop_prev & tx_starved)
        next_per = 1'b1;
    end
    if (transmit_buffer_clear_in)
    begin
      next_tx_full = txf_valid;
      next_tx_empty = ~txf_valid;
      next_tx_buf = txf_valid ? txf_data : tx_buf;
    end
    else if (tx_load_in & tx_full)
    begin
      next_tx_shift_data = tx_buf;
      next_tx_full = txf_valid;
      next_tx_empty = ~txf_valid;
      next_tx_buf = txf_valid ? txf_data : tx_buf;
    end
    else if (tx_buf_write)
    begin
      next_tx_buf = tx_write_data_in;
      next_tx_full = 1'b1;
      next_tx_empty = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      clk_meta <= 1'b1; // idle-high pin; no false edge after reset
      clk_sync <= 1'b1;
      clk_prev <= 1'b1;
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      baud_half <= 1'b0;
      timer_ff <= 1'b0;
      stop_prev <= 1'b0;
      rx_hist <= 3'h7;
      rx_filt <= 1'b1;
      div_cnt <= `SCBF_DIV_RST;
      serial_shift_clock_out <= 1'b0;
      bit_tick_out <= 1'b0;
      rx_bit_out <= 1'b1;
      rx_bit_valid_out <= 1'b0;
      rx_buf <= `SCBF_BYTE_RST;
      rx_full <= 1'b0;
      rx_data_out <= `SCBF_BYTE_RST;
      tx_buf <= `SCBF_BYTE_RST;
      tx_full <= 1'b0;
      tx_empty <= 1'b1;
      tx_shift_data_out <= `SCBF_BYTE_RST;
      ovr <= 1'b0;
      per <= 1'b0;
      fer <= 1'b0;
      prescaler_run_out <= 1'b0;
      transmit_running_flag_out <= 1'b0;
    end
    else
    begin
      clk_meta <= serial_clock_pin_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      rxd_meta <= rx_pin_in;
      rxd_sync <= rxd_meta;
      baud_half <= next_baud_half;
      timer_ff <= next_timer_ff;
      stop_prev <= clock_stop;
      rx_hist <= next_rx_hist;
      rx_filt <= next_rx_filt;
      div_cnt <= next_div_cnt;
      serial_shift_clock_out <= next_shift_clock;
      bit_tick_out <= next_bit_tick;
      rx_bit_out <= next_rx_bit;
      rx_bit_valid_out <= next_rx_bit_valid;
      rx_buf <= next_rx_buf;
      rx_full <= next_rx_full;
      rx_data_out <= next_rx_data;
      tx_buf <= next_tx_buf;
      tx_full <= next_tx_full;
      tx_empty <= next_tx_empty;
      tx_shift_data_out <= next_tx_shift_data;
      ovr <= next_ovr;
      per <= next_per;
      fer <= next_fer;
      prescaler_run_out <= ~io_mode & (uart_clock_select_in == `SCBF_CSEL_BAUD);
      transmit_running_flag_out <= ~tx_shift_idle_in;
    end
  end

  // outputs straight from flops, except the clock pin enable decoded from the mode inputs
  assign serial_clock_pin_out = baud_half;
  assign serial_clock_pin_oe_out = io_clk_out;
  assign clock_stopped_out = stop_prev;
  assign transmit_buffer_empty_flag_out = tx_empty;
  assign receive_buffer_full_flag_out = rx_full;
  assign overrun_flag_out = ovr;
  assign parity_underrun_flag_out = per;
  assign framing_flag_out = fer;
endmodule : scbf_core

// *** verification/scbf_remote.sv ***
// remote device model that supplies the external serial clock
module scbf_remote (
  input wire logic clock_in,
  input wire logic run_in,
  output logic sclk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase = 0;
  initial sclk_out = 1'b1;
  // ten-cycle period, low half then high half; idles high with no edges when not asked
  always @(posedge clock_in)
  begin
    phase <= run_in ? (phase + 1) % 10 : 0;
    sclk_out <= !(run_in && phase < 5);
  end
endmodule : scbf_remote

// *** verification/scbf_core_asserts.sv ***
// assertion checker for the serial clock, buffer and flag block
`include "scbf_params.svh"
module scbf_core_asserts (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire scbf_pkg::scbf_code_type mode_select_in,
  input wire logic io_clock_input_in,
  input wire scbf_pkg::scbf_code_type uart_clock_select_in,
  input wire logic rx_frame_done_in,
  input wire logic rx_stop_bit_in,
  input wire logic status_read_in,
  input wire logic control_read_in,
  input wire logic tx_write_in,
  input wire logic tx_load_in,
  input wire logic transmit_buffer_clear_in,
  input wire logic serial_clock_pin_oe_out,
  input wire logic prescaler_run_out,
  input wire logic transmit_buffer_empty_flag_out,
  input wire logic receive_buffer_full_flag_out,
  input wire logic overrun_flag_out,
  input wire logic parity_underrun_flag_out,
  input wire logic framing_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import scbf_pkg::*;
  // one clock domain; reset disables every check
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  AST_PIN_OE: assert property (
    serial_clock_pin_oe_out == (mode_select_in == `SCBF_MODE_IO && !io_clock_input_in))
    else $error("clock pin enable wrong");
  AST_PRESCALE: assert property (
    !$past(rst_in) && $past(mode_select_in) != `SCBF_MODE_IO |->
    prescaler_run_out == ($past(uart_clock_select_in) == `SCBF_CSEL_BAUD))
    else $error("prescaler run wrong");
  AST_EMPTY_SET: assert property (
    $rose(transmit_buffer_empty_flag_out) |-> $past(tx_load_in || transmit_buffer_clear_in))
    else $error("empty flag set without cause");
  AST_EMPTY_CLR: assert property (
    $fell(transmit_buffer_empty_flag_out) |-> $past(tx_write_in))
    else $error("empty flag cleared without write");
  AST_FULL_SET: assert property (
    $rose(receive_buffer_full_flag_out) |-> $past(rx_frame_done_in))
    else $error("full flag set without frame");
  AST_FULL_CLR: assert property (
    $past(status_read_in && !rx_frame_done_in && !rst_in) |-> !receive_buffer_full_flag_out)
    else $error("full flag kept after read");
  AST_ERR_CLR: assert property (
    $past(control_read_in && !rx_frame_done_in && !rst_in && mode_select_in != `SCBF_MODE_IO)
    |-> !(overrun_flag_out || parity_underrun_flag_out || framing_flag_out))
    else $error("error flags kept after read");
  AST_FRAMING: assert property (
    $rose(framing_flag_out) |-> $past(rx_frame_done_in && !rx_stop_bit_in))
    else $error("framing set without bad stop bit");
  // main scenarios reached
  cover property (overrun_flag_out);
  cover property ($rose(framing_flag_out));
  cover property ($fell(transmit_buffer_empty_flag_out));
endmodule : scbf_core_asserts

bind scbf_core scbf_core_asserts u_chk (
  .clock_in, .rst_in, .mode_select_in, .io_clock_input_in, .uart_clock_select_in,
  .rx_frame_done_in, .rx_stop_bit_in, .status_read_in, .control_read_in, .tx_write_in,
  .tx_load_in, .transmit_buffer_clear_in, .serial_clock_pin_oe_out, .prescaler_run_out,
  .transmit_buffer_empty_flag_out, .receive_buffer_full_flag_out, .overrun_flag_out,
  .parity_underrun_flag_out, .framing_flag_out
);

// *** verification/scbf_core_test.sv ***
// self-checking bench for the serial clock, buffer and flag block
`include "scbf_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module scbf_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import scbf_pkg::*;
  localparam logic [8:0] FRM = 9'h100, RRD = 9'h080, SRD = 9'h040, CRD = 9'h020;
  localparam logic [8:0] RFC = 9'h010, TFC = 9'h008, WR = 9'h004, LD = 9'h002, CLR = 9'h001;
  logic clock_in = 0, rst_in = 1, io_clock_input_in = 0, edge_select_in = 0, run = 0;
  logic double_buffer_in = 0, fifo_enable_in = 0, parity_enable_in = 0, parity_even_in = 0;
  logic baud_clock_in = 0, timer_match_in = 0, rx_pin_in = 1, rx_parity_bit_in = 0;
  logic rx_stop_bit_in = 1, tx_shift_idle_in = 1;
  scbf_code_type mode_select_in = 2'h1, uart_clock_select_in = 2'h0, duplex_select_in = 2'h0;
  scbf_byte_type rx_frame_data_in = 8'h00, tx_write_data_in = 8'h00;
  scbf_byte_type tx_shift_data_out, rx_data_out;
  scbf_level_type rx_fifo_level_out, tx_fifo_level_out;
  logic [8:0] p = 9'h000;
  wire logic serial_clock_pin_in;
  logic rx_frame_done_in, rx_read_in, status_read_in, control_read_in, rx_fifo_clear_in;
  logic tx_fifo_clear_in, tx_write_in, tx_load_in, transmit_buffer_clear_in;
  logic tx_write_ready_out, serial_clock_pin_out, serial_clock_pin_oe_out;
  logic serial_shift_clock_out, bit_tick_out, prescaler_run_out, rx_bit_out;
  logic rx_bit_valid_out, clock_stopped_out, transmit_running_flag_out;
  logic transmit_buffer_empty_flag_out, receive_buffer_full_flag_out, overrun_flag_out;
  logic parity_underrun_flag_out, framing_flag_out;
  logic [2:0] rows [4] = '{3'h0, 3'h3, 3'h4, 3'h6};
  int error_cnt = 0, compares = 0, i;
  integer sc_cnt = 0, bt_cnt = 0, vc_cnt = 0, s0, s1;
  // one-cycle request pulses
  assign {rx_frame_done_in, rx_read_in, status_read_in, control_read_in, rx_fifo_clear_in,
    tx_fifo_clear_in, tx_write_in, tx_load_in, transmit_buffer_clear_in} = p;
  scbf_core u_dut (.*);
  scbf_remote u_far (.clock_in, .run_in(run), .sclk_out(serial_clock_pin_in));
  // clock and tick counters
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    sc_cnt <= sc_cnt + serial_shift_clock_out;
    bt_cnt <= bt_cnt + bit_tick_out;
    vc_cnt <= vc_cnt + rx_bit_valid_out;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock_in);
  endtask : w
  task automatic pulse(input logic [8:0] v);
    @(posedge clock_in);
    p <= v;
    @(posedge clock_in);
    p <= 9'h000;
    #1;
  endtask : pulse
  task automatic baud(input int n);
    repeat (n)
    begin
      @(posedge clock_in);
      baud_clock_in <= 1'b1;
      @(posedge clock_in);
      baud_clock_in <= 1'b0;
    end
  endtask : baud
  task automatic frame(input scbf_byte_type d, input logic pb, input logic sb);
    @(posedge clock_in);
    rx_frame_data_in <= d;
    rx_parity_bit_in <= pb;
    rx_stop_bit_in <= sb;
    pulse(FRM);
  endtask : frame
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // cut a hung run short
  initial
  begin
    w(6000);
    error_cnt++;
    test_done();
  end
  // main sequence
  initial
  begin
    w(16);
    rst_in <= 1'b0;
    w(1);
    #1;
    `CHK({transmit_buffer_empty_flag_out, receive_buffer_full_flag_out}, 2'h2)
    `CHK({overrun_flag_out, parity_underrun_flag_out, framing_flag_out}, 3'h0)
    for (i = 0; i < 4; i++)
    begin
      w(1);
      uart_clock_select_in <= rows[i][2:1];
      w(2);
      #1;
      `CHK(prescaler_run_out, rows[i][0])
    end
    w(1);
    uart_clock_select_in <= `SCBF_CSEL_SYS;
    rx_pin_in <= 1'b0;
    w(4);
    #1;
    s0 = bt_cnt;
    s1 = vc_cnt;
    w(160);
    #1;
    `CHK(bt_cnt - s0, 10)
    `CHK(vc_cnt - s1, 10)
    `CHK(rx_bit_out, 1'b0)
    w(1);
    rx_pin_in <= 1'b1;
    uart_clock_select_in <= `SCBF_CSEL_TIMER;
    w(3);
    #1;
    s0 = sc_cnt;
    repeat (8)
    begin
      w(1);
      timer_match_in <= 1'b1;
      w(1);
      timer_match_in <= 1'b0;
      w(2);
    end
    w(4);
    #1;
    `CHK(sc_cnt - s0, 4)
    w(1);
    double_buffer_in <= 1'b1;
    tx_write_data_in <= 8'h5a;
    pulse(WR);
    `CHK(transmit_buffer_empty_flag_out, 1'b0)
    pulse(LD);
    `CHK({transmit_buffer_empty_flag_out, tx_shift_data_out}, 9'h15a)
    frame(8'h3c, 1'b0, 1'b1);
    `CHK(receive_buffer_full_flag_out, 1'b1)
    pulse(SRD);
    `CHK(receive_buffer_full_flag_out, 1'b0)
    pulse(RRD);
    `CHK(rx_data_out, 8'h3c)
    frame(8'h01, 1'b0, 1'b1);
    frame(8'h02, 1'b0, 1'b1);
    `CHK(overrun_flag_out, 1'b1)
    pulse(RRD);
    `CHK(rx_data_out, 8'h01)
    pulse(CRD);
    `CHK(overrun_flag_out, 1'b0)
    w(1);
    parity_enable_in <= 1'b1;
    parity_even_in <= 1'b1;
    frame(8'h01, 1'b0, 1'b0);
    `CHK({parity_underrun_flag_out, framing_flag_out}, 2'h3)
    pulse(RRD);
    pulse(CRD);
    `CHK({overrun_flag_out, parity_underrun_flag_out, framing_flag_out}, 3'h0)
    frame(8'h01, 1'b1, 1'b1);
    `CHK({parity_underrun_flag_out, framing_flag_out}, 2'h0)
    pulse(RRD);
    w(1);
    parity_enable_in <= 1'b0;
    fifo_enable_in <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      w(1);
      duplex_select_in <= i ? `SCBF_DPX_FULL : `SCBF_DPX_RX;
      pulse(RFC | TFC);
      repeat (5 - 2 * i) frame(8'h40, 1'b0, 1'b1);
      w(2);
      #1;
      `CHK({overrun_flag_out, rx_fifo_level_out}, 5'(4 - 2 * i))
      frame(8'h41, 1'b0, 1'b1);
      `CHK(overrun_flag_out, 1'b1)
      repeat (5 - 2 * i) pulse(RRD);
      pulse(CRD);
    end
    w(1);
    duplex_select_in <= `SCBF_DPX_TX;
    pulse(RFC | TFC);
    for (i = 1; i < 4; i++)
    begin
      w(1);
      tx_write_data_in <= 8'(i);
      pulse(WR);
    end
    `CHK({transmit_running_flag_out, tx_fifo_level_out}, 5'h02)
    pulse(CLR);
    `CHK({transmit_buffer_empty_flag_out, tx_fifo_level_out}, 5'h01)
    pulse(CLR);
    pulse(CLR);
    `CHK({transmit_buffer_empty_flag_out, tx_fifo_level_out}, 5'h10)
    w(1);
    fifo_enable_in <= 1'b0;
    mode_select_in <= `SCBF_MODE_IO;
    io_clock_input_in <= 1'b1;
    tx_shift_idle_in <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      w(1);
      edge_select_in <= i[0];
      w(4);
      #1;
      `CHK(serial_clock_pin_oe_out, 1'b0)
      s0 = sc_cnt;
      w(1);
      run <= 1'b1;
      w(100);
      run <= 1'b0;
      w(8);
      #1;
      `CHK(sc_cnt - s0, 10)
    end
    // clock-out i/o: halved baud clock, then stop when transmit runs dry
    w(1);
    io_clock_input_in <= 1'b0;
    w(2);
    #1;
    s0 = sc_cnt;
    baud(8);
    w(2);
    #1;
    `CHK(sc_cnt - s0, 4)
    `CHK({serial_clock_pin_oe_out, serial_clock_pin_out}, 2'h2)
    w(1);
    tx_shift_idle_in <= 1'b1;
    w(3);
    #1;
    `CHK({clock_stopped_out, parity_underrun_flag_out, tx_write_ready_out}, 3'h7)
    s0 = sc_cnt;
    baud(2);
    w(2);
    #1;
    `CHK(sc_cnt - s0, 0)
    `CHK(serial_clock_pin_out, 1'b0)
    w(1);
    double_buffer_in <= 1'b0;
    tx_shift_idle_in <= 1'b0;
    w(2);
    #1;
    `CHK(tx_write_ready_out, 1'b0)
    pulse(CRD);
    `CHK({overrun_flag_out, parity_underrun_flag_out, framing_flag_out}, 3'h0)
    w(1);
    mode_select_in <= 2'h1;
    w(2);
    #1;
    `CHK(serial_clock_pin_oe_out, 1'b0)
    test_done();
  end
endmodule : scbf_core_test
